// File: verilog/irqseq_top.sv
// Interrupt recognition and service sequencer for a small 8-bit core.
// How it works
// - Three sources: pin, tick timer, trap.
// - Entry stacks state, masks, loads vector.
// - Entry sequence lasts eleven instruction cycles.
// - Return instruction unstacks saved state.
// - Hardware requests wait for instruction end.
// - Boundary check picks unmasked request.
// - Masked requests stay latched until unmasked.
// - Pin request beats timer request.
// - Pin synchronized; falling edge sets pending.
// - Edge detector re-arms on high level.
// - Trap runs even with mask set.
// - Hardware requests serviced ahead of trap.
// - Reset aborts current instruction immediately.
// - Pin level readable for branch tests.
// - Tick request bit 7, mask bit 6.
// - Mask flag blocks pin and tick.
`timescale 1ns/10ps
`include "irqseq_consts.svh"
module irqseq_top
   import irqseq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // External interrupt pin, active low
   input wire logic ext_int_n,
   // Timer side
   input wire logic tick_zero,
   input wire logic tick_req_clr,
   input wire logic tick_mask_wr,
   input wire logic tick_mask_val,
   output logic [7:0] tick_ctrl_reg,
   // Core handshake
   input wire logic instr_done,
   input wire logic soft_trap_instr,
   input wire logic trap_return_instr,
   input wire logic mask_clr,
   input wire logic [10:0] cur_pc,
   input wire logic [4:0] cur_cc,
   input wire logic [7:0] cur_a,
   input wire logic [7:0] cur_x,
   // Vector memory read
   output logic [10:0] vec_addr_ff,
   output logic vec_rd_ff,
   input wire logic [7:0] vec_data,
   // Results to the core
   output logic core_hold,
   output logic mask_flag_ff,
   output logic pin_level_ff,
   output logic [10:0] new_pc_ff,
   output logic new_pc_load_ff,
   output logic [4:0] rest_cc_ff,
   output logic [7:0] rest_a_ff,
   output logic [7:0] rest_x_ff,
   output logic restore_ff,
   output logic [1:0] taken_src_ff
);
   // ============================================================
   // Declarations
   irqseq_state_type state_ff;
   irqseq_src_type src_ff;
   logic [2:0] pin_sync_ff;
   logic pin_armed_ff;
   logic ext_pend_ff;
   logic tick_req_ff;
   logic tick_mask_ff;
   logic [`IRQSEQ_CNT_W-1:0] cnt_ff;
   logic [`IRQSEQ_IDX_W-1:0] idx_ff;
   logic [4:0] sp_ff;
   logic [39:0] frame_ff;
   logic [7:0] vec_hi_ff;
   logic [7:0] vec_lo_ff;
   logic vec_ack_ff;
   logic vec_ack_lo_ff;
   logic ram_wr;
   logic [4:0] ram_addr_w;
   logic [4:0] ram_addr_r;
   logic [7:0] ram_rd;
   logic ext_go;
   logic tick_go;
   logic hw_go;
   logic ext_fall;
   logic ext_take;
   logic pin_stable;

   localparam logic [`IRQSEQ_CNT_W-1:0] ENTRY_LAST =
      `IRQSEQ_CNT_W'(`IRQSEQ_ENTRY_CLKS - 1);
   localparam logic [`IRQSEQ_IDX_W-1:0] LAST_BYTE =
      `IRQSEQ_IDX_W'(`IRQSEQ_STACK_BYTES - 1);
   localparam logic [10:0] SP_FULL = `IRQSEQ_SP_RESET;

   // Vector address of a source.
   function automatic logic [10:0] vec_of(input irqseq_src_type s);
      unique case (s)
         IRQSEQ_SRC_EXT: vec_of = `IRQSEQ_VEC_EXT;
         IRQSEQ_SRC_TICK: vec_of = `IRQSEQ_VEC_TICK;
         default: vec_of = `IRQSEQ_VEC_TRAP;
      endcase
   endfunction

   // Stacked byte number i of a frame, PC low byte first.
   function automatic logic [7:0] frame_byte(input logic [39:0] f,
                                             input logic [2:0] i);
      frame_byte = f[8*i +: 8];
   endfunction

   // ============================================================
   // Pin synchronizer
   // three stage sync
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_sync_ff <= 3'h7;
      end else begin
         pin_sync_ff <= {pin_sync_ff[1:0], ext_int_n};
      end
   end
   // A level counts only once the second and third stages agree.
   assign pin_stable = (pin_sync_ff[1] == pin_sync_ff[2]);

   // Polled pin level follows the agreed level.
   // pin level out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_level_ff <= 1'h1;
      end else if (pin_stable) begin
         pin_level_ff <= pin_sync_ff[2];
      end
   end

   // ============================================================
   // Edge detector and pending latch
   assign ext_fall = pin_stable && !pin_sync_ff[2] && pin_armed_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_armed_ff <= 1'h0;
      end else if (ext_fall) begin
         pin_armed_ff <= 1'h0;
      end else if (pin_stable && pin_sync_ff[2]) begin
         pin_armed_ff <= 1'h1;
      end
   end

   // Set wins over the clear so an edge in the taking cycle is kept.
   // latch falling edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_pend_ff <= 1'h0;
      end else if (ext_fall) begin
         ext_pend_ff <= 1'h1;
      end else if (ext_take) begin
         ext_pend_ff <= 1'h0;
      end
   end

   // ============================================================
   // Tick control register
   // request bit set on zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_req_ff <= 1'h0;
      end else if (tick_zero) begin
         tick_req_ff <= 1'h1;
      end else if (tick_req_clr) begin
         tick_req_ff <= 1'h0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_mask_ff <= 1'h1;
      end else if (tick_mask_wr) begin
         tick_mask_ff <= tick_mask_val;
      end
   end

   // Unused low bits read as ones.
   always_comb begin
      tick_ctrl_reg = 8'hFF;
      tick_ctrl_reg[`IRQSEQ_TICK_REQ_BIT] = tick_req_ff;
      tick_ctrl_reg[`IRQSEQ_TICK_MASK_BIT] = tick_mask_ff;
   end

   // ============================================================
   // Boundary arbitration
   // mask flag gates both
   assign ext_go = ext_pend_ff && !mask_flag_ff;
   assign tick_go = tick_req_ff && !tick_mask_ff && !mask_flag_ff;
   assign hw_go = ext_go || tick_go;
   assign ext_take = (state_ff == IRQSEQ_RUN) && instr_done && ext_go;
   assign core_hold = (state_ff != IRQSEQ_RUN);

   // ============================================================
   // Sequencer
   // three sources
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= IRQSEQ_RUN;
         src_ff <= IRQSEQ_SRC_NONE;
         cnt_ff <= '0;
         idx_ff <= '0;
         frame_ff <= '0;
      end else begin
         unique case (state_ff)
            IRQSEQ_RUN: begin
               cnt_ff <= '0;
               idx_ff <= '0;
               if (instr_done && hw_go) begin
                  state_ff <= IRQSEQ_PUSH;
                  src_ff <= ext_go ? IRQSEQ_SRC_EXT : IRQSEQ_SRC_TICK;
                  frame_ff <= {3'h0, cur_cc, cur_a, cur_x, 5'h00, cur_pc};
               end else if (instr_done && soft_trap_instr) begin
                  state_ff <= IRQSEQ_PUSH;
                  src_ff <= IRQSEQ_SRC_TRAP;
                  frame_ff <= {3'h0, cur_cc, cur_a, cur_x, 5'h00, cur_pc};
               end else if (instr_done && trap_return_instr) begin
                  state_ff <= IRQSEQ_PULL;
               end
            end
            IRQSEQ_PUSH: begin
               cnt_ff <= cnt_ff + 1'h1;
               if (idx_ff == LAST_BYTE) begin
                  state_ff <= IRQSEQ_VEC;
               end else begin
                  idx_ff <= idx_ff + 1'h1;
               end
            end
            IRQSEQ_VEC: begin
               cnt_ff <= cnt_ff + 1'h1;
               state_ff <= IRQSEQ_WAIT;
            end
            IRQSEQ_WAIT: begin
               cnt_ff <= cnt_ff + 1'h1;
               if (cnt_ff == ENTRY_LAST) begin
                  state_ff <= IRQSEQ_RUN;
               end
            end
            IRQSEQ_PULL: begin
               idx_ff <= idx_ff + 1'h1;
               if (idx_ff == `IRQSEQ_IDX_W'(`IRQSEQ_STACK_BYTES)) begin
                  state_ff <= IRQSEQ_RUN;
               end
            end
            default: begin
               state_ff <= IRQSEQ_RUN;
            end
         endcase
      end
   end

   // ============================================================
   // Stack pointer, in the five low bits of the fixed stack page.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sp_ff <= SP_FULL[4:0];
      end else if (state_ff == IRQSEQ_PUSH) begin
         sp_ff <= sp_ff - 1'h1;
      end else if (state_ff == IRQSEQ_PULL &&
                   idx_ff < `IRQSEQ_IDX_W'(`IRQSEQ_STACK_BYTES)) begin
         sp_ff <= sp_ff + 1'h1;
      end
   end

   assign ram_wr = (state_ff == IRQSEQ_PUSH);
   assign ram_addr_w = sp_ff;
   assign ram_addr_r = sp_ff + 5'h01;

   irqseq_stack_ram u_stack (
      .clk(clk),
      .wr_en(ram_wr),
      .wr_addr(ram_addr_w),
      .wr_data(frame_byte(frame_ff, idx_ff)),
      .rd_addr(ram_addr_r),
      .rd_data_ff(ram_rd)
   );

   // Pulled bytes come back one cycle late: CC, A, X, PC high, PC low.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rest_cc_ff <= '0;
         rest_a_ff <= '0;
         rest_x_ff <= '0;
         restore_ff <= 1'h0;
      end else begin
         restore_ff <= (state_ff == IRQSEQ_PULL) &&
                       (idx_ff == `IRQSEQ_IDX_W'(`IRQSEQ_STACK_BYTES));
         if (state_ff == IRQSEQ_PULL) begin
            unique case (idx_ff)
               3'h1: rest_cc_ff <= ram_rd[4:0];
               3'h2: rest_a_ff <= ram_rd;
               3'h3: rest_x_ff <= ram_rd;
               default: ;
            endcase
         end
      end
   end

   // ============================================================
   // Mask flag: set on entry, restored on return, cleared by core.
   // set mask on entry
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_flag_ff <= 1'h1;
      end else if (state_ff == IRQSEQ_VEC) begin
         mask_flag_ff <= 1'h1;
      end else if (restore_ff) begin
         mask_flag_ff <= rest_cc_ff[3];
      end else if (mask_clr) begin
         mask_flag_ff <= 1'h0;
      end
   end

   // ============================================================
   // Vector fetch and new program counter
   // high byte first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vec_addr_ff <= '0;
         vec_rd_ff <= 1'h0;
         vec_hi_ff <= '0;
         vec_lo_ff <= '0;
         new_pc_ff <= '0;
         new_pc_load_ff <= 1'h0;
         taken_src_ff <= IRQSEQ_SRC_NONE;
      end else begin
         new_pc_load_ff <= 1'h0;
         vec_rd_ff <= 1'h0;
         if (state_ff == IRQSEQ_PUSH && idx_ff == LAST_BYTE) begin
            vec_addr_ff <= vec_of(src_ff);
            vec_rd_ff <= 1'h1;
            taken_src_ff <= src_ff;
         end else if (state_ff == IRQSEQ_VEC) begin
            vec_addr_ff <= vec_of(src_ff) + 11'h001;
            vec_rd_ff <= 1'h1;
         end else if (vec_ack_ff && !vec_ack_lo_ff) begin
            vec_hi_ff <= vec_data;
         end else if (vec_ack_ff) begin
            vec_lo_ff <= vec_data;
         end else if (state_ff == IRQSEQ_WAIT && cnt_ff == ENTRY_LAST) begin
            new_pc_ff <= {vec_hi_ff[2:0], vec_lo_ff};
            new_pc_load_ff <= 1'h1;
         end else if (state_ff == IRQSEQ_PULL && idx_ff == 3'h4) begin
            vec_hi_ff <= ram_rd;
         end else if (state_ff == IRQSEQ_PULL &&
                      idx_ff == `IRQSEQ_IDX_W'(`IRQSEQ_STACK_BYTES)) begin
            new_pc_ff <= {vec_hi_ff[2:0], ram_rd};
            new_pc_load_ff <= 1'h1;
         end
      end
   end

   // Vector bytes stand only in the cycle after each strobe, so both are caught then.
   // The memory is free to change its data later, long before the entry ends.
   // capture after strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vec_ack_ff <= 1'h0;
         vec_ack_lo_ff <= 1'h0;
      end else begin
         vec_ack_ff <= vec_rd_ff;
         vec_ack_lo_ff <= vec_rd_ff && (state_ff == IRQSEQ_WAIT);
      end
   end
endmodule // irqseq_top

// File: verilog/irqseq_consts.svh
// Constants for the interrupt sequencer: vectors, timing and field positions.
`ifndef IRQSEQ_CONSTS_SVH
`define IRQSEQ_CONSTS_SVH
// ============================================================
// Timing
`define IRQSEQ_CLK_PERIOD_NS 20
`define IRQSEQ_INSTR_CYCLE_NS 1000
`define IRQSEQ_CYC_CLKS (`IRQSEQ_INSTR_CYCLE_NS / `IRQSEQ_CLK_PERIOD_NS)
`define IRQSEQ_ENTRY_CYCLES 11
`define IRQSEQ_ENTRY_CLKS (`IRQSEQ_ENTRY_CYCLES * `IRQSEQ_CYC_CLKS)
`define IRQSEQ_CNT_W 10
// ============================================================
// Tick control register fields
`define IRQSEQ_TICK_REQ_BIT 7
`define IRQSEQ_TICK_MASK_BIT 6
// ============================================================
// Stacked frame: five bytes, program counter low byte first
`define IRQSEQ_STACK_BYTES 5
`define IRQSEQ_IDX_W 3
`define IRQSEQ_VEC_EXT 11'h7FA
`define IRQSEQ_VEC_TICK 11'h7F8
`define IRQSEQ_VEC_TRAP 11'h7FC
`define IRQSEQ_SP_RESET 11'h07F
`endif

// File: verilog/irqseq_pkg.sv
// Types shared by the interrupt sequencer files.
package irqseq_pkg;
   // ============================================================
   // Sequencer states
   typedef enum logic [4:0] {
      IRQSEQ_RUN   = 5'h01,
      IRQSEQ_PUSH  = 5'h02,
      IRQSEQ_VEC   = 5'h04,
      IRQSEQ_WAIT  = 5'h08,
      IRQSEQ_PULL  = 5'h10
   } irqseq_state_type;
   // Source of the interrupt being taken
   typedef enum logic [1:0] {
      IRQSEQ_SRC_NONE = 2'h0,
      IRQSEQ_SRC_EXT  = 2'h1,
      IRQSEQ_SRC_TICK = 2'h2,
      IRQSEQ_SRC_TRAP = 2'h3
   } irqseq_src_type;
endpackage

// File: verilog/irqseq_stack_ram.sv
// Small stack memory for the saved processor frames, registered read.
`timescale 1ns/10ps
module irqseq_stack_ram (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Read port
   input wire logic [4:0] rd_addr,
   output logic [7:0] rd_data_ff
);
   // ============================================================
   // Storage
   logic [7:0] mem [0:31];

   // Write and registered read; no reset so it maps to RAM.
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
   end
endmodule // irqseq_stack_ram

// File: dv/irqseq_src_model.sv
// Model of the external interrupt source and the timer zero strobe.
`timescale 1ns/10ps
module irqseq_src_model (
   // Clock
   input wire logic clk,
   // Commands from the bench
   input wire logic pin_go,
   input wire logic tick_go,
   // Request lines toward the sequencer
   output logic ext_int_n = 1'b1,
   output logic tick_zero = 1'b0
);
   int cnt = 0;
   // pin period
   // Low for 60 clocks, then high for at least 61: each at least one instruction cycle plus 200 ns.
   always @(posedge clk) begin
      if (pin_go && cnt == 0) begin
         cnt <= 120;
         ext_int_n <= 1'b0;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
         ext_int_n <= (cnt <= 61);
      end
   end
   // timer strobe
   // The counter reaching zero is a one-cycle strobe.
   always @(posedge clk) tick_zero <= tick_go;
endmodule // irqseq_src_model

// File: dv/irqseq_checker.sv
// Concurrent checks on the ports of the interrupt sequencer.
`timescale 1ns/10ps
module irqseq_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched signals
   input wire logic instr_done,
   input wire logic soft_trap_instr,
   input wire logic trap_return_instr,
   input wire logic tick_zero,
   input wire logic tick_req_clr,
   input wire logic [7:0] tick_ctrl_reg,
   input wire logic core_hold,
   input wire logic mask_flag_ff,
   input wire logic [10:0] vec_addr_ff,
   input wire logic vec_rd_ff,
   input wire logic new_pc_load_ff,
   input wire logic restore_ff
);
   // The hold lasts 550 clocks; the load flag is seen at the edge after that.
   localparam int ENTRY = 551;
   wire take = instr_done && !core_hold;
   // ============================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   entry_length_a: assert property (take && soft_trap_instr && !trap_return_instr
      |-> ##[ENTRY:ENTRY] new_pc_load_ff && !restore_ff) else $error("entry length wrong");
   return_length_a: assert property (take && trap_return_instr && !soft_trap_instr
      && mask_flag_ff |-> ##7 new_pc_load_ff && restore_ff) else $error("return length wrong");
   trap_always_a: assert property (take && soft_trap_instr |=> core_hold)
      else $error("trap not taken");
   no_abort_a: assert property (!core_hold && !instr_done |=> !core_hold)
      else $error("hold rose mid instruction");
   mask_blocks_a: assert property (take && mask_flag_ff && !soft_trap_instr
      && !trap_return_instr |=> !core_hold) else $error("masked request taken");
   entry_mask_a: assert property (new_pc_load_ff && !restore_ff |-> mask_flag_ff)
      else $error("mask not set on entry");
   vector_range_a: assert property (vec_rd_ff |-> vec_addr_ff inside {[11'h7F8:11'h7FD]})
      else $error("vector read out of range");
   tick_set_a: assert property (tick_zero |=> tick_ctrl_reg[7])
      else $error("tick request not set");
   tick_keep_a: assert property (tick_ctrl_reg[7] && !tick_req_clr |=> tick_ctrl_reg[7])
      else $error("tick request lost");
   tick_clear_a: assert property (tick_req_clr && !tick_zero |=> !tick_ctrl_reg[7])
      else $error("tick request not cleared");
   // Main scenarios.
   cover property (take && soft_trap_instr && mask_flag_ff);
   cover property (new_pc_load_ff && restore_ff);
   cover property (vec_rd_ff && vec_addr_ff == 11'h7FA);
endmodule // irqseq_checker
bind irqseq_top irqseq_checker u_chk (.clk, .rst, .instr_done, .soft_trap_instr,
   .trap_return_instr, .tick_zero, .tick_req_clr, .tick_ctrl_reg, .core_hold,
   .mask_flag_ff, .vec_addr_ff, .vec_rd_ff, .new_pc_load_ff, .restore_ff);

// File: dv/tb_interrupt_sequencer.sv
// Self-checking bench for the interrupt sequencer.
`timescale 1ns/10ps
`include "irqseq_consts.svh"
module tb_interrupt_sequencer
   import irqseq_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, ext_int_n, tick_zero, tick_mask_val = 1'b0;
   logic instr_done = 1'b0, soft_trap_instr = 1'b0, trap_return_instr = 1'b0;
   logic vec_rd_ff, core_hold, mask_flag_ff, pin_level_ff, new_pc_load_ff, restore_ff;
   logic [4:0] strobe = 5'h00, cur_cc = 5'h00, rest_cc_ff, sv_cc;
   logic [10:0] cur_pc = 11'h000, vec_addr_ff, new_pc_ff, sv_pc;
   logic [7:0] cur_a = 8'h00, cur_x = 8'h00, vec_data = 8'h00, tick_ctrl_reg;
   logic [7:0] rest_a_ff, rest_x_ff, sv_a, sv_x;
   logic [1:0] taken_src_ff;
   logic [31:0] seed = 32'h43;
   int fail_count = 0, checks = 0, lat;
   wire pin_go = strobe[0], tick_go = strobe[1], mask_clr = strobe[2];
   wire tick_mask_wr = strobe[3], tick_req_clr = strobe[4];
   // Clock of 20 ns.
   always #10 clk = ~clk;
   irqseq_top dut (.clk, .rst, .ext_int_n, .tick_zero, .tick_req_clr, .tick_mask_wr,
      .tick_mask_val, .tick_ctrl_reg, .instr_done, .soft_trap_instr, .trap_return_instr,
      .mask_clr, .cur_pc, .cur_cc, .cur_a, .cur_x, .vec_addr_ff, .vec_rd_ff, .vec_data,
      .core_hold, .mask_flag_ff, .pin_level_ff, .new_pc_ff, .new_pc_load_ff, .rest_cc_ff,
      .rest_a_ff, .rest_x_ff, .restore_ff, .taken_src_ff);
   irqseq_src_model u_src (.clk, .pin_go, .tick_go, .ext_int_n, .tick_zero);
   // Vector memory answers a cycle after the strobe; between reads its data keeps moving.
   always @(posedge clk) vec_data <= vec_rd_ff ? vbyte(vec_addr_ff) : ~vec_data;
   // ============================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [7:0] vbyte(input logic [10:0] a);
      return a[7:0] ^ 8'hA5;
   endfunction
   // Handler address: high byte at the base, low byte next.
   function automatic logic [10:0] exp_vec(input logic [10:0] base);
      logic [7:0] hi;
      hi = vbyte(base);
      return {hi[2:0], vbyte(base + 11'h001)};
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      strobe[k] <= 1'b1;
      @(posedge clk);
      strobe[k] <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   // One instruction end with a random frame; waits for the hold to drop, bounded.
   task automatic instr(input logic trap, input logic ret);
      seed = xs(seed);
      @(posedge clk);
      instr_done <= 1'b1;
      soft_trap_instr <= trap;
      trap_return_instr <= ret;
      {cur_pc, cur_cc, cur_a, cur_x} <= seed;
      if (trap) {sv_pc, sv_cc, sv_a, sv_x} = seed;
      @(posedge clk);
      instr_done <= 1'b0;
      soft_trap_instr <= 1'b0;
      trap_return_instr <= 1'b0;
      lat = 1;
      @(negedge clk);
      while (core_hold === 1'b1 && lat < 1000) begin
         @(negedge clk);
         lat++;
      end
      check("hold_end", lat < 1000, 1'b1);
   endtask
   task automatic taken(input string name, input logic [1:0] src, input logic [10:0] base);
      check("long", lat > 540, 1'b1);
      check("src", taken_src_ff, src);
      check("pc", new_pc_ff, exp_vec(base));
      check("mask", mask_flag_ff, 1'b1);
      $display("test %s done", name);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ============================================================
   // Tests
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("hold_rst", core_hold, 1'b0);
      check("mask_rst", mask_flag_ff, 1'b1);
      check("tcr_rst", tick_ctrl_reg, 8'h7F);
      check("pin_rst", pin_level_ff, 1'b1);
      instr(1'b1, 1'b0);
      taken("trap_masked", IRQSEQ_SRC_TRAP, `IRQSEQ_VEC_TRAP);
      pulse(0);
      pulse(1);
      check("pin_low", pin_level_ff, 1'b0);
      check("tick_req", tick_ctrl_reg[7], 1'b1);
      instr(1'b0, 1'b0);
      check("held", lat, 1);
      pulse(2);
      instr(1'b0, 1'b0);
      taken("pin_late", IRQSEQ_SRC_EXT, `IRQSEQ_VEC_EXT);
      pulse(2);
      instr(1'b0, 1'b0);
      check("tick_masked", lat, 1);
      pulse(3);
      check("tick_mask", tick_ctrl_reg[6], 1'b0);
      pulse(0);
      instr(1'b1, 1'b0);
      taken("pin_first", IRQSEQ_SRC_EXT, `IRQSEQ_VEC_EXT);
      pulse(2);
      instr(1'b0, 1'b0);
      taken("tick_next", IRQSEQ_SRC_TICK, `IRQSEQ_VEC_TICK);
      check("tick_stays", tick_ctrl_reg[7], 1'b1);
      pulse(4);
      check("tick_clr", tick_ctrl_reg[7], 1'b0);
      pulse(2);
      instr(1'b1, 1'b0);
      taken("trap_open", IRQSEQ_SRC_TRAP, `IRQSEQ_VEC_TRAP);
      instr(1'b0, 1'b1);
      check("ret_pc", new_pc_ff, sv_pc);
      check("ret_frame", {rest_cc_ff, rest_a_ff}, {sv_cc, sv_a});
      check("ret_x", rest_x_ff, sv_x);
      // The mask comes back one clock after the restore strobe.
      @(negedge clk);
      check("ret_mask", mask_flag_ff, sv_cc[3]);
      @(posedge clk);
      instr_done <= 1'b1;
      soft_trap_instr <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
      soft_trap_instr <= 1'b0;
      repeat (100) @(posedge clk);
      rst <= 1'b1;
      @(negedge clk);
      check("abort", {core_hold, mask_flag_ff}, 2'h1);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      $display("test reset_abort done");
      finish_test();
   end
   // Watchdog well beyond the six entries the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      finish_test();
   end
endmodule // tb_interrupt_sequencer
